// File: core/rx_recovery.sv
// Receive clock and data recovery with a two-entry receive buffer.
`timescale 1ns/1ps
// What this block does
// - Sixteen samples per bit normally, eight in double-speed mode.
// - Double-speed sampling is used when the double-speed select bit is one.
// - In idle, a falling edge starts start detection; first low sample is one.
// - Start checked on samples 8,9,10 normally, or 4,5,6 in double speed.
// - Two or more high start samples reject the start as noise.
// - A valid start realigns sample timing afresh for every frame.
// - Per-bit state counter steps 16 or 8 states; samples numbered by state.
// - Data and parity bits resolve by two-of-three majority vote.
// - Votes start at sample 8 normally, at sample 4 in double speed.
// - Recovery runs through the first stop bit; later stop bits ignored.
// - A first stop bit voting zero sets the frame error flag.
// - Next start edge is watched right after the stop decision sample, one past the last vote.
// - Payload length, character plus parity, is five to ten bits.
// - Frame error is buffered with its frame and advances on reads.
// - Clearing receiver enable aborts reception and empties the buffer.
module rx_recovery (
  input wire logic clk,
  input wire logic rst,
  input wire rx_recovery_pkg::rx_config_t cfg,
  input wire logic rx_line,
  input wire logic read_strobe,
  output logic receive_complete_flag,
  output rx_recovery_pkg::rx_word_t serial_data_buffer,
  output logic frame_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sync;
    logic line;
    logic prev;
    logic [15:0] div_count;
    rx_recovery_pkg::rx_state_t state;
    logic [4:0] sample;
    logic [2:0] votes;
    logic [3:0] bit_index;
    logic [9:0] shift;
    rx_recovery_pkg::rx_word_t [1:0] buffer;
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
  } rx_regs_t;

  rx_regs_t r;
  rx_regs_t next_r;
  logic tick;
  logic fall;
  logic [4:0] per_bit;
  logic [4:0] vote_first;
  logic [3:0] plen;
  logic voted;
  logic push;
  logic pop;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    push = 1'b0;
    pop = 1'b0;
    voted = majority(r.votes);
    per_bit = cfg.double_speed_select ? rx_recovery_pkg::SAMPLES_DOUBLE
                                      : rx_recovery_pkg::SAMPLES_NORMAL;
    vote_first = cfg.double_speed_select ? rx_recovery_pkg::VOTE_FIRST_DOUBLE
                                         : rx_recovery_pkg::VOTE_FIRST_NORMAL;
    plen = cfg.payload_bits;
    if (plen < rx_recovery_pkg::PAYLOAD_MIN) begin
      plen = rx_recovery_pkg::PAYLOAD_MIN;
    end
    if (plen > rx_recovery_pkg::PAYLOAD_MAX) begin
      plen = rx_recovery_pkg::PAYLOAD_MAX;
    end
    // Three-stage synchroniser; a change counts when the last two agree.
    next_r.sync = {r.sync[1:0], rx_line};
    if (r.sync[2] == r.sync[1]) begin
      next_r.line = r.sync[2];
    end
    tick = (r.div_count == cfg.baud_divider_value);
    next_r.div_count = tick ? 16'h0000 : r.div_count + 16'h0001;
    // The level seen at each tick is kept, so only a high-to-low step starts a frame.
    if (tick) begin
      next_r.prev = r.line;
    end
    fall = tick && r.prev && !r.line;
    unique case (r.state)
      rx_recovery_pkg::ST_IDLE: begin
        if (fall) begin
          next_r.state = rx_recovery_pkg::ST_START;
          next_r.sample = 5'h01;
          next_r.votes = 3'h0;
        end
      end
      rx_recovery_pkg::ST_START,
      rx_recovery_pkg::ST_DATA,
      rx_recovery_pkg::ST_STOP: begin
        if (tick) begin
          next_r.sample = r.sample + 5'h01;
          if (r.sample >= vote_first && r.sample <= vote_first + 5'h02) begin
            next_r.votes = {r.votes[1:0], r.line};
          end
          if (r.sample == vote_first + 5'h03) begin
            if (r.state == rx_recovery_pkg::ST_START && voted) begin
              next_r.state = rx_recovery_pkg::ST_IDLE;
            end else if (r.state == rx_recovery_pkg::ST_STOP) begin
              // The stop bit is done one sample after its last vote; idle watches at once.
              push = 1'b1;
              next_r.state = rx_recovery_pkg::ST_IDLE;
            end else if (r.state == rx_recovery_pkg::ST_DATA) begin
              next_r.shift = {voted, r.shift[9:1]};
            end
          end
          if (r.sample == per_bit) begin
            next_r.sample = 5'h01;
            if (r.state == rx_recovery_pkg::ST_START) begin
              next_r.state = rx_recovery_pkg::ST_DATA;
              next_r.bit_index = 4'h0;
              next_r.shift = 10'h000;
            end else if (r.state == rx_recovery_pkg::ST_DATA) begin
              next_r.bit_index = r.bit_index + 4'h1;
              if (r.bit_index + 4'h1 == plen) begin
                next_r.state = rx_recovery_pkg::ST_STOP;
              end
            end
          end
        end
      end
    endcase
    if (push && r.count != 2'h2) begin
      next_r.buffer[r.wr_ptr].payload = r.shift >> (4'hA - plen);
      next_r.buffer[r.wr_ptr].frame_error_flag = ~voted;
      next_r.wr_ptr = ~r.wr_ptr;
    end
    pop = read_strobe && r.count != 2'h0;
    if (pop) begin
      next_r.rd_ptr = ~r.rd_ptr;
    end
    next_r.count = r.count + {1'b0, push && r.count != 2'h2} - {1'b0, pop};
    if (!cfg.receiver_enable_bit) begin
      next_r.state = rx_recovery_pkg::ST_IDLE;
      next_r.count = 2'h0;
      next_r.rd_ptr = 1'b0;
      next_r.wr_ptr = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{sync: 3'h7, line: 1'b1, prev: 1'b1, div_count: 16'h0000,
             state: rx_recovery_pkg::ST_IDLE, sample: 5'h00, votes: 3'h0,
             bit_index: 4'h0, shift: 10'h000, buffer: '0, count: 2'h0,
             rd_ptr: 1'b0, wr_ptr: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign receive_complete_flag = (r.count != 2'h0);
  assign serial_data_buffer = r.buffer[r.rd_ptr];
  assign frame_active = (r.state != rx_recovery_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  // Ticks of a running frame, and the decision points within it.
  logic busy_tick;
  logic start_decide;
  logic data_decide;
  logic bit_end;
  assign busy_tick = tick && cfg.receiver_enable_bit && r.state != rx_recovery_pkg::ST_IDLE;
  assign start_decide = busy_tick && r.state == rx_recovery_pkg::ST_START
                        && r.sample == vote_first + 5'h03;
  assign data_decide = busy_tick && r.state == rx_recovery_pkg::ST_DATA
                       && r.sample == vote_first + 5'h03;
  assign bit_end = busy_tick && r.sample == per_bit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence start_seen;
    r.state == rx_recovery_pkg::ST_IDLE && fall && cfg.receiver_enable_bit;
  endsequence

  start_entry_a: assert property (@(posedge clk) disable iff (rst)
    start_seen |=> r.state == rx_recovery_pkg::ST_START && r.sample == 5'h01)
    else $error("start detection not entered on falling edge");

  sample_limit_a: assert property (@(posedge clk) disable iff (rst)
    r.state != rx_recovery_pkg::ST_IDLE |-> r.sample <= per_bit && r.sample != 5'h00)
    else $error("sample counter out of range");

  noise_reject_a: assert property (@(posedge clk) disable iff (rst)
    r.state == rx_recovery_pkg::ST_START && tick && r.sample == vote_first + 5'h03 && voted
    |=> r.state == rx_recovery_pkg::ST_IDLE)
    else $error("noisy start not rejected");

  disable_flush_a: assert property (@(posedge clk) disable iff (rst)
    !cfg.receiver_enable_bit |=> !receive_complete_flag && !frame_active)
    else $error("disable did not flush receiver");

  stop_push_a: assert property (@(posedge clk) disable iff (rst)
    r.state == rx_recovery_pkg::ST_STOP && tick && r.sample == vote_first + 5'h03
    && cfg.receiver_enable_bit |=> r.state == rx_recovery_pkg::ST_IDLE)
    else $error("stop bit did not end frame");

  frame_error_a: assert property (@(posedge clk) disable iff (rst)
    r.state == rx_recovery_pkg::ST_STOP && tick && r.sample == vote_first + 5'h03
    && cfg.receiver_enable_bit && r.count == 2'h0 && !voted
    |=> receive_complete_flag && serial_data_buffer.frame_error_flag)
    else $error("frame error not recorded");

  tick_only_a: assert property (@(posedge clk) disable iff (rst)
    !tick && cfg.receiver_enable_bit |=> r.sample == $past(r.sample))
    else $error("sample advanced without tick");

  speed_count_a: assert property (@(posedge clk) disable iff (rst)
    cfg.double_speed_select && r.state != rx_recovery_pkg::ST_IDLE |-> r.sample <= 5'h08)
    else $error("double speed exceeded eight samples");

  sync_hold_a: assert property (@(posedge clk) disable iff (rst)
    r.sync[2] != r.sync[1] |=> r.line == $past(r.line))
    else $error("line level changed before synchroniser settled");

  sync_take_a: assert property (@(posedge clk) disable iff (rst)
    r.sync[2] == r.sync[1] |=> r.line == $past(r.sync[2]))
    else $error("settled line level not taken");

  no_edge_a: assert property (@(posedge clk) disable iff (rst)
    r.state == rx_recovery_pkg::ST_IDLE && tick && !r.prev
    |=> r.state == rx_recovery_pkg::ST_IDLE)
    else $error("frame started without a falling edge");

  start_keep_a: assert property (@(posedge clk) disable iff (rst)
    start_decide && !voted
    |=> r.state == rx_recovery_pkg::ST_START)
    else $error("valid start bit was dropped");

  realign_a: assert property (@(posedge clk) disable iff (rst)
    bit_end && r.state == rx_recovery_pkg::ST_START
    |=> r.state == rx_recovery_pkg::ST_DATA && r.sample == 5'h01)
    else $error("data recovery not aligned to start bit");

  sample_step_a: assert property (@(posedge clk) disable iff (rst)
    busy_tick && r.sample != per_bit
    |=> r.sample == $past(r.sample) + 5'h01)
    else $error("sample counter did not step on tick");

  vote_one_a: assert property (@(posedge clk) disable iff (rst)
    data_decide && $countones(r.votes) > 1
    |=> r.shift[9])
    else $error("majority high bit not resolved as one");

  vote_zero_a: assert property (@(posedge clk) disable iff (rst)
    data_decide && $countones(r.votes) < 2
    |=> !r.shift[9])
    else $error("majority low bit not resolved as zero");

  vote_window_a: assert property (@(posedge clk) disable iff (rst)
    busy_tick && r.sample == vote_first
    |=> r.votes[0] == $past(r.line))
    else $error("first voting sample not taken");

  vote_quiet_a: assert property (@(posedge clk) disable iff (rst)
    busy_tick && r.sample == vote_first - 5'h01
    |=> r.votes == $past(r.votes))
    else $error("sample taken before voting window");

  stop_enter_a: assert property (@(posedge clk) disable iff (rst)
    bit_end && r.state == rx_recovery_pkg::ST_DATA && r.bit_index + 4'h1 == plen
    |=> r.state == rx_recovery_pkg::ST_STOP)
    else $error("stop bit not reached after payload length");

  index_range_a: assert property (@(posedge clk) disable iff (rst)
    r.state == rx_recovery_pkg::ST_DATA
    |-> r.bit_index < plen)
    else $error("bit index beyond payload length");

  stop_clean_a: assert property (@(posedge clk) disable iff (rst)
    busy_tick && r.state == rx_recovery_pkg::ST_STOP && r.sample == vote_first + 5'h03
    && r.count == 2'h0 && voted |=> !serial_data_buffer.frame_error_flag)
    else $error("frame error set on good stop bit");

  pop_step_a: assert property (@(posedge clk) disable iff (rst)
    read_strobe && receive_complete_flag && cfg.receiver_enable_bit
    |=> r.rd_ptr != $past(r.rd_ptr))
    else $error("read did not advance buffer head");

  full_drop_a: assert property (@(posedge clk) disable iff (rst)
    busy_tick && r.state == rx_recovery_pkg::ST_STOP && r.sample == vote_first + 5'h03
    && r.count == 2'h2 && !read_strobe |=> r.count == 2'h2)
    else $error("full buffer count changed on dropped frame");

endmodule // rx_recovery

// File: core/rx_recovery_pkg.sv
// Shared constants and carrier types for the serial receive recovery block.
package rx_recovery_pkg;

  // ----------------------------------------------------------------
  // Sampling constants
  // ----------------------------------------------------------------
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] PAYLOAD_MIN = 4'h5;
  localparam logic [3:0] PAYLOAD_MAX = 4'hA;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  localparam int BUFFER_DEPTH = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } rx_state_t;

  typedef struct packed {
    logic [9:0] payload;
    logic frame_error_flag;
  } rx_word_t;

  typedef struct packed {
    logic double_speed_select;
    logic receiver_enable_bit;
    logic [3:0] payload_bits;
    logic [15:0] baud_divider_value;
  } rx_config_t;

endpackage

// File: verif/rx_line_model.sv
// Behavioural remote transmitter driving the serial receive line.
`timescale 1ns/1ps
module rx_line_model (
  input wire logic clk,
  output logic line
);
  initial begin
    line = 1'b1;
  end

  // Sends start and nbits data bits lsb first, bit_clk cycles each, then one stop bit lasting stop_clk cycles.
  // The exact rate keeps the error far inside both receiver bands.
  task automatic send(input logic [9:0] data, input int nbits, input logic stop,
                      input int bit_clk, input int stop_clk);
    @(posedge clk);
    line <= 1'b0;
    repeat (bit_clk) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line <= data[i];
      repeat (bit_clk) @(posedge clk);
    end
    line <= stop;
    repeat (stop_clk) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule // rx_line_model

// File: verif/rx_recovery_tb.sv
// Self-checking bench for the serial receive recovery block.
`timescale 1ns/1ps
module rx_recovery_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rx_recovery_pkg::rx_config_t cfg = '{1'b0, 1'b1, 4'h8, 16'h0000};
  logic rx_line;
  logic read_strobe = 1'b0;
  logic receive_complete_flag;
  rx_recovery_pkg::rx_word_t serial_data_buffer;
  logic frame_active;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  rx_recovery rx_recovery_i (
    .clk(clk),
    .rst(rst),
    .cfg(cfg),
    .rx_line(rx_line),
    .read_strobe(read_strobe),
    .receive_complete_flag(receive_complete_flag),
    .serial_data_buffer(serial_data_buffer),
    .frame_active(frame_active)
  );

  rx_line_model rx_line_model_i (
    .clk(clk),
    .line(rx_line)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic set_cfg(input logic ds, input logic en, input logic [3:0] bits);
    @(posedge clk);
    cfg <= '{ds, en, bits, 16'h0000};
    repeat (20) @(posedge clk);
  endtask

  task automatic wait_flag();
    for (int i = 0; i < 400 && receive_complete_flag !== 1'b1; i++) @(negedge clk);
    check({10'h000, receive_complete_flag}, 11'h001);
  endtask

  task automatic pop();
    @(posedge clk);
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    set_cfg(1'b0, 1'b1, 4'h8);
    rx_line_model_i.send(10'h0A5, 8, 1'b1, 16, 16);
    wait_flag();
    check(serial_data_buffer, {10'h0A5, 1'b0});
    pop();
    check({10'h000, receive_complete_flag}, 11'h000);
  endtask

  task automatic t_clamp();
    set_cfg(1'b0, 1'b1, 4'h3);
    rx_line_model_i.send(10'h01B, 5, 1'b1, 16, 16);
    wait_flag();
    check(serial_data_buffer, {10'h01B, 1'b0});
    pop();
  endtask

  task automatic t_abort();
    set_cfg(1'b0, 1'b1, 4'h8);
    fork
      rx_line_model_i.send(10'h033, 8, 1'b1, 16, 16);
      begin
        repeat (60) @(posedge clk);
        cfg.receiver_enable_bit <= 1'b0;
        repeat (2) @(negedge clk);
        check({10'h000, frame_active}, 11'h000);
      end
    join
    repeat (4) @(negedge clk);
    check({9'h000, frame_active, receive_complete_flag}, 11'h000);
  endtask

  task automatic t_double_error();
    set_cfg(1'b1, 1'b1, 4'hA);
    rx_line_model_i.send(10'h2C3, 10, 1'b0, 8, 8);
    wait_flag();
    check(serial_data_buffer, {10'h2C3, 1'b1});
    pop();
  endtask

  task automatic t_noise();
    set_cfg(1'b0, 1'b1, 4'h8);
    rx_line_model_i.send(10'h000, 0, 1'b1, 8, 1);
    repeat (40) @(negedge clk);
    check({9'h000, frame_active, receive_complete_flag}, 11'h000);
  endtask

  task automatic t_burst();
    set_cfg(1'b0, 1'b1, 4'h5);
    rx_line_model_i.send(10'h015, 5, 1'b1, 16, 11);
    rx_line_model_i.send(10'h00A, 5, 1'b1, 16, 11);
    rx_line_model_i.send(10'h01F, 5, 1'b1, 16, 16);
    check(serial_data_buffer, {10'h015, 1'b0});
    pop();
    check(serial_data_buffer, {10'h00A, 1'b0});
    pop();
    check({10'h000, receive_complete_flag}, 11'h000);
  endtask

  task automatic t_disable();
    set_cfg(1'b0, 1'b1, 4'h8);
    rx_line_model_i.send(10'h055, 8, 1'b1, 16, 16);
    wait_flag();
    @(posedge clk);
    cfg.receiver_enable_bit <= 1'b0;
    repeat (3) @(negedge clk);
    check({10'h000, receive_complete_flag}, 11'h000);
    rx_line_model_i.send(10'h0FF, 8, 1'b1, 16, 16);
    check({10'h000, receive_complete_flag}, 11'h000);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_normal();
    t_double_error();
    t_noise();
    t_burst();
    t_clamp();
    t_abort();
    t_disable();
    close_out();
  end
endmodule // rx_recovery_tb
